// File: hdl/reset_sequencer_pkg.sv
/*
  constants, types and state codes shared by the reset sequencer and its
  system integrity register; assumes a single 125 MHz cpu clock.
  //Contract
  //- external pin, low supply and watchdog start a sequence; pin low throughout delay.
  //- after reset the cpu starts from the vector at the top two bytes.
  //- each reset runs active phase, then fixed delay, then vector fetch.
  //- delay is 256 or 4096 cpu cycles, chosen by option setting.
  //- vector fetch lasts exactly two clock cycles before running.
  //- a crystal or resonator oscillator keeps running during reset.
  //- reset pin is input and open-drain output; outside may pull it low.
  //- external low pulse is caught asynchronously, even with clock stopped.
  //- recognised external pulse is stretched to the minimum output width.
  //- pin held low while the low supply detector reports low supply.
  //- watchdog underflow drives pin low for at least the minimum width.
  //- low supply threshold selectable low, medium or high by option.
  //- low supply detector enabled by option; disabled gives no supply reset.
  //- detector low flag is real-time and read-only; writes ignored.
  //- auxiliary detector works only when low supply detector is enabled.
  //- source select clear: watch main supply, threshold tied to lvd choice.
  //- with irq enabled every toggle of the detector flag raises a request.
  //- a crossing before the reset delay ends raises no request.
  //- enabling while flag low-voltage raises one request at once.
  //- source select set: watch the external voltage sense pin.
  //- watchdog cause flag set by watchdog, cleared by zero write or lvd reset.
*/
package reset_sequencer_pkg;

  // register map and field layout of the system integrity register
  localparam logic [7:0]  SI_REG_ADDR     = 8'h00;
  localparam int          BIT_SRC_SEL     = 7;
  localparam int          BIT_IRQ_EN      = 6;
  localparam int          BIT_LOW_FLAG    = 5;
  localparam int          BIT_LVD_CAUSE   = 4;
  localparam int          BIT_WDG_CAUSE   = 0;
  localparam logic [7:0]  SI_REG_RESET    = 8'h00;

  // reset vector location
  localparam logic [15:0] VECTOR_LO_ADDR  = 16'hfffe;
  localparam logic [15:0] VECTOR_HI_ADDR  = 16'hffff;

  // timing
  localparam int          CLK_MHZ         = 125;
  localparam int          DELAY_SHORT     = 256;
  localparam int          DELAY_LONG      = 4096;
  localparam int          FETCH_CYCLES    = 2;
  localparam int          RST_OUT_MIN_NS  = 20000;
  localparam int          RST_OUT_CYCLES  = (RST_OUT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W           = 13;

  // sequence phases
  typedef enum logic [1:0] {
    PH_ACTIVE,
    PH_DELAY,
    PH_FETCH,
    PH_RUN
  } phase_e;

  // option byte settings, stable while the part runs
  typedef struct packed {
    logic       longDelay;
    logic       lvdEnable;
    logic [1:0] lvdThreshold;
    logic       crystalOsc;
  } options_s;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage

// File: hdl/reset_sequencer.sv
/*
  reset sequencer with low supply and auxiliary supply detector logic.
  assumes analog comparator outputs and option settings are synchronous to
  clk, the pin level reflects the open-drain wire with weak pull-up, and
  the watchdog underflow arrives as a one-cycle pulse.
*/
module reset_sequencer #(
  parameter int SHORT_DELAY    = reset_sequencer_pkg::DELAY_SHORT,
  parameter int LONG_DELAY     = reset_sequencer_pkg::DELAY_LONG,
  parameter int STRETCH_CYCLES = reset_sequencer_pkg::RST_OUT_CYCLES
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire reset_sequencer_pkg::reg_req_s regReq,
  output logic [7:0]                         regRdData,
  // open-drain reset pin
  input  wire logic                          rstPinIn,
  output logic                               rstPinOut,
  output logic                               rstPinOe,
  // option settings and reset causes
  input  wire reset_sequencer_pkg::options_s opts,
  input  wire logic                          lowSupplyCmp,
  input  wire logic                          watchdogUnderflow,
  // auxiliary detector comparators
  input  wire logic                          auxCmpSupply,
  input  wire logic                          auxCmpPin,
  input  wire logic                          auxIrqAck,
  // analog steering
  output logic [1:0]                         lvdThresholdSel,
  output logic [1:0]                         auxThresholdSel,
  output logic                               auxSourceSel,
  output logic                               oscKeepRunning,
  // cpu side
  output logic                               cpuReset,
  output logic                               vectorFetch,
  output logic [15:0]                        vectorAddr,
  output logic                               cpuRun,
  output logic                               auxIrq
);

  localparam int CW = reset_sequencer_pkg::CNT_W;

  // parameter sanity: counters are CW bits wide
  if (SHORT_DELAY < 1 || LONG_DELAY < 1 || STRETCH_CYCLES < 1 ||
      SHORT_DELAY >= (1 << CW) || LONG_DELAY >= (1 << CW) ||
      STRETCH_CYCLES >= (1 << CW))
  begin : g_bad_params
    $error("reset_sequencer: delay or stretch count out of range");
  end

  localparam logic [CW-1:0] SHORT_LAST   = CW'(SHORT_DELAY - 1);
  localparam logic [CW-1:0] LONG_LAST    = CW'(LONG_DELAY - 1);
  localparam logic [CW-1:0] STRETCH_LAST = CW'(STRETCH_CYCLES - 1);
  localparam logic [CW-1:0] FETCH_LAST   = CW'(reset_sequencer_pkg::FETCH_CYCLES - 1);

  reset_sequencer_pkg::phase_e phase_q;
  reset_sequencer_pkg::phase_e phase_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          stretchDone_q;
  logic          stretchDone_d;
  logic          delayLong_q;
  logic          extSeen_q;
  logic          extLow;
  logic          lvdLow;
  logic          newCause;
  logic          srcSel_q;
  logic          irqEn_q;
  logic          lowFlag_q;
  logic          lvdCause_q;
  logic          wdgCause_q;
  logic          auxCmp;
  logic          auxIrq_q;
  logic [7:0]    rdData_q;
  logic          siWrite;
  logic          irqEvent;
  logic          pinOe_q;
  logic          pinOut_q;
  logic [1:0]    lvdThr_q;
  logic          oscKeep_q;
  logic          cpuReset_q;
  logic          vectorFetch_q;
  logic [15:0]   vectorAddr_q;
  logic          cpuRun_q;

  // low supply reset only exists when the detector is enabled
  // a disabled detector can never hold the part in reset
  assign lvdLow   = opts.lvdEnable & lowSupplyCmp;
  // pin pulled low by someone else while we are not driving it
  assign extLow   = ~rstPinIn & ~pinOe_q;
  assign newCause = lvdLow | watchdogUnderflow;
  assign siWrite  = regReq.wr && (regReq.addr == reset_sequencer_pkg::SI_REG_ADDR);

  // external pulse catcher, set without the clock so halt cannot miss it
  always_ff @(posedge clk or posedge extLow)
  begin
    if (extLow)
      extSeen_q <= 1'b1;
    else if (rst)
      extSeen_q <= 1'b0;
    else if (phase_q == reset_sequencer_pkg::PH_DELAY)
      extSeen_q <= 1'b0;
  end

  // phase sequencing and cycle counting
  always_comb
  begin
    phase_d       = phase_q;
    cnt_d         = cnt_q;
    stretchDone_d = stretchDone_q;
    case (phase_q)
      reset_sequencer_pkg::PH_ACTIVE:
      begin
        if (watchdogUnderflow)
        begin
          cnt_d         = '0;
          stretchDone_d = 1'b0;
        end
        else if (!stretchDone_q)
        begin
          if (cnt_q == STRETCH_LAST)
          begin
            cnt_d         = '0;
            stretchDone_d = 1'b1;
          end
          else
            cnt_d = cnt_q + 1'b1;
        end
        else if (!lvdLow && rstPinIn && !pinOe_q)
        begin
          // every cause released: start the fixed delay
          phase_d = reset_sequencer_pkg::PH_DELAY;
          cnt_d   = '0;
        end
      end
      reset_sequencer_pkg::PH_DELAY:
      begin
        if (newCause)
        begin
          phase_d       = reset_sequencer_pkg::PH_ACTIVE;
          cnt_d         = '0;
          stretchDone_d = 1'b0;
        end
        else if (cnt_q == (delayLong_q ? LONG_LAST : SHORT_LAST))
        begin
          phase_d = reset_sequencer_pkg::PH_FETCH;
          cnt_d   = '0;
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
      reset_sequencer_pkg::PH_FETCH,
      reset_sequencer_pkg::PH_RUN:
      begin
        if (newCause || extSeen_q)
        begin
          phase_d       = reset_sequencer_pkg::PH_ACTIVE;
          cnt_d         = '0;
          stretchDone_d = 1'b0;
        end
        else if (phase_q == reset_sequencer_pkg::PH_FETCH)
        begin
          if (cnt_q == FETCH_LAST)
          begin
            phase_d = reset_sequencer_pkg::PH_RUN;
            cnt_d   = '0;
          end
          else
            cnt_d = cnt_q + 1'b1;
        end
      end
      default:
      begin
        phase_d       = reset_sequencer_pkg::PH_ACTIVE;
        cnt_d         = '0;
        stretchDone_d = 1'b0;
      end
    endcase
  end

  // sequence state, power-up enters the active phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_q       <= reset_sequencer_pkg::PH_ACTIVE;
      cnt_q         <= '0;
      stretchDone_q <= 1'b0;
    end
    else
    begin
      phase_q       <= phase_d;
      cnt_q         <= cnt_d;
      stretchDone_q <= stretchDone_d;
    end
  end

  // delay length taken from the option setting as the delay starts
  always_ff @(posedge clk)
  begin
    if (rst)
      delayLong_q <= 1'b0;
    else if (phase_q != reset_sequencer_pkg::PH_DELAY)
      delayLong_q <= opts.longDelay;
  end

  // open-drain pin drive: stretch, low supply and the whole delay phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinOe_q  <= 1'b1;
      pinOut_q <= 1'b0;
    end
    else
    begin
      pinOut_q <= 1'b0;
      pinOe_q  <= (phase_d == reset_sequencer_pkg::PH_DELAY) ||
                  (phase_d == reset_sequencer_pkg::PH_ACTIVE &&
                   (!stretchDone_d || lvdLow));
    end
  end

  // cpu side: held in reset, then two vector fetch cycles, then run
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpuReset_q    <= 1'b1;
      vectorFetch_q <= 1'b0;
      vectorAddr_q  <= reset_sequencer_pkg::VECTOR_LO_ADDR;
      cpuRun_q      <= 1'b0;
    end
    else
    begin
      cpuReset_q    <= (phase_d == reset_sequencer_pkg::PH_ACTIVE) ||
                       (phase_d == reset_sequencer_pkg::PH_DELAY);
      vectorFetch_q <= (phase_d == reset_sequencer_pkg::PH_FETCH);
      vectorAddr_q  <= (phase_d == reset_sequencer_pkg::PH_FETCH && cnt_d != '0) ?
                       reset_sequencer_pkg::VECTOR_HI_ADDR :
                       reset_sequencer_pkg::VECTOR_LO_ADDR;
      cpuRun_q      <= (phase_d == reset_sequencer_pkg::PH_RUN);
    end
  end

  // analog steering copies the option setting every cycle, reset included:
  // the comparator threshold and the oscillator must be valid while the
  // part is held in reset, so these copies are deliberately not cleared
  // and never lag a setting that changed under reset by more than a cycle
  always_ff @(posedge clk)
  begin
    lvdThr_q  <= opts.lvdThreshold;
    oscKeep_q <= opts.crystalOsc;
  end

  // software control bits, cleared by rst and throughout the active phase
  always_ff @(posedge clk)
  begin
    if (rst || phase_q == reset_sequencer_pkg::PH_ACTIVE)
    begin
      srcSel_q <= reset_sequencer_pkg::SI_REG_RESET[reset_sequencer_pkg::BIT_SRC_SEL];
      irqEn_q  <= reset_sequencer_pkg::SI_REG_RESET[reset_sequencer_pkg::BIT_IRQ_EN];
    end
    else if (siWrite)
    begin
      srcSel_q <= regReq.wrData[reset_sequencer_pkg::BIT_SRC_SEL];
      irqEn_q  <= regReq.wrData[reset_sequencer_pkg::BIT_IRQ_EN];
    end
  end

  // reset cause flags: hardware set wins over a software clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lvdCause_q <= 1'b0;
      wdgCause_q <= 1'b0;
    end
    else
    begin
      if (lvdLow)
        lvdCause_q <= 1'b1;
      else if (siWrite && !regReq.wrData[reset_sequencer_pkg::BIT_LVD_CAUSE])
        lvdCause_q <= 1'b0;
      if (watchdogUnderflow)
        wdgCause_q <= 1'b1;
      else if (lvdLow)
        wdgCause_q <= 1'b0;
      else if (siWrite && !regReq.wrData[reset_sequencer_pkg::BIT_WDG_CAUSE])
        wdgCause_q <= 1'b0;
    end
  end

  // auxiliary detector flag follows the selected comparator in real time
  assign auxCmp = srcSel_q ? auxCmpPin : auxCmpSupply;

  always_ff @(posedge clk)
  begin
    if (rst)
      lowFlag_q <= 1'b0;
    else
      lowFlag_q <= opts.lvdEnable & auxCmp;
  end

  // toggle while running, or enabling while the flag reports low voltage
  assign irqEvent = cpuRun_q && opts.lvdEnable &&
                    ((irqEn_q && (lowFlag_q != (opts.lvdEnable & auxCmp))) ||
                     (siWrite && !irqEn_q && lowFlag_q &&
                      regReq.wrData[reset_sequencer_pkg::BIT_IRQ_EN]));

  // pending request, cleared on acknowledge; a new event wins
  always_ff @(posedge clk)
  begin
    if (rst || !cpuRun_q)
      auxIrq_q <= 1'b0;
    else if (irqEvent)
      auxIrq_q <= 1'b1;
    else if (auxIrqAck || !irqEn_q)
      auxIrq_q <= 1'b0;
  end

  // register read: data stands in the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (rst)
      rdData_q <= 8'h00;
    else if (regReq.rd && regReq.addr == reset_sequencer_pkg::SI_REG_ADDR)
      rdData_q <= {srcSel_q, irqEn_q, lowFlag_q, lvdCause_q,
                   3'h0, wdgCause_q};
    else
      rdData_q <= 8'h00;
  end

  // outputs straight from flops; the pin is open-drain, so only the
  // enable ever moves and the driven level stays low
  assign regRdData       = rdData_q;
  assign rstPinOut       = pinOut_q;
  assign rstPinOe        = pinOe_q;
  assign lvdThresholdSel = lvdThr_q;
  assign auxThresholdSel = lvdThr_q;
  assign auxSourceSel    = srcSel_q;
  assign oscKeepRunning  = oscKeep_q;
  assign cpuReset        = cpuReset_q;
  assign vectorFetch     = vectorFetch_q;
  assign vectorAddr      = vectorAddr_q;
  assign cpuRun          = cpuRun_q;
  assign auxIrq          = auxIrq_q;

endmodule

// File: dv/reset_sequencer_checker.sv
/*
  port-level assertions for the reset sequencer.
  assumes one clock and the sync active-high reset of the design.
*/
module reset_sequencer_checker #(
  parameter int SHORT_DELAY    = 16,
  parameter int LONG_DELAY     = 64,
  parameter int STRETCH_CYCLES = 8
) (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          rst,
  // register port
  input wire reset_sequencer_pkg::reg_req_s regReq,
  input wire logic [7:0]                    regRdData,
  // pin, options and causes
  input wire logic                          rstPinIn,
  input wire logic                          rstPinOe,
  input wire reset_sequencer_pkg::options_s opts,
  input wire logic                          lowSupplyCmp,
  input wire logic                          watchdogUnderflow,
  // steering and cpu side
  input wire logic [1:0]                    lvdThresholdSel,
  input wire logic [1:0]                    auxThresholdSel,
  input wire logic                          oscKeepRunning,
  input wire logic                          cpuReset,
  input wire logic                          vectorFetch,
  input wire logic [15:0]                   vectorAddr,
  input wire logic                          cpuRun,
  input wire logic                          auxIrq
);
  logic [15:0] oeRun_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // counts consecutive cycles the device pulls the pin low
  always_ff @(posedge clk)
    if (rst || !rstPinOe)
      oeRun_q <= 16'h0000;
    else
      oeRun_q <= oeRun_q + 16'h0001;

  a_fetch_order: assert property ($rose(vectorFetch) |->
    vectorAddr == reset_sequencer_pkg::VECTOR_LO_ADDR ##1 vectorFetch
    && vectorAddr == reset_sequencer_pkg::VECTOR_HI_ADDR ##1 !vectorFetch && cpuRun)
    else $error("vector fetch order wrong");
  a_delay_length: assert property ($rose(vectorFetch) |->
    oeRun_q == (opts.longDelay ? LONG_DELAY : SHORT_DELAY))
    else $error("delay phase length wrong");
  a_stretch_min: assert property ($fell(rstPinOe) |-> oeRun_q >= STRETCH_CYCLES)
    else $error("pin released too early");
  a_wdg_drive: assert property (watchdogUnderflow |=> rstPinOe)
    else $error("watchdog did not drive pin");
  a_low_supply: assert property (opts.lvdEnable && lowSupplyCmp |=> rstPinOe && !cpuRun)
    else $error("low supply did not hold pin");
  a_aux_off: assert property (!opts.lvdEnable |=> !auxIrq && !regRdData[5])
    else $error("aux detector active while off");
  a_ext_catch: assert property (!rstPinIn && !rstPinOe && cpuRun |-> ##[1:2] rstPinOe)
    else $error("external pulse not caught");
  a_irq_in_run: assert property ($rose(auxIrq) |-> $past(cpuRun))
    else $error("aux request outside run");
  a_run_clean: assert property (cpuRun |-> !cpuReset && !rstPinOe && !vectorFetch)
    else $error("run overlaps reset phases");
  a_opt_copies: assert property (lvdThresholdSel == $past(opts.lvdThreshold)
    && auxThresholdSel == $past(opts.lvdThreshold) && oscKeepRunning == $past(opts.crystalOsc))
    else $error("option copies wrong");
  a_read_window: assert property (regRdData != 8'h00 |-> $past(regReq.rd))
    else $error("read data outside window");
endmodule

bind reset_sequencer reset_sequencer_checker #(
  .SHORT_DELAY(SHORT_DELAY), .LONG_DELAY(LONG_DELAY), .STRETCH_CYCLES(STRETCH_CYCLES)
) chk (.clk, .rst, .regReq, .regRdData, .rstPinIn, .rstPinOe, .opts, .lowSupplyCmp,
  .watchdogUnderflow, .lvdThresholdSel, .auxThresholdSel, .oscKeepRunning, .cpuReset,
  .vectorFetch, .vectorAddr, .cpuRun, .auxIrq);

// File: dv/reset_pin_partner.sv
/*
  outside reset circuitry on the shared open-drain reset wire.
  assumes a weak pull-up; the bench commands when outside pulls low.
*/
module reset_pin_partner (
  // device side of the wire
  input  wire logic rstPinOe,
  input  wire logic rstPinOut,
  // outside pull command
  input  wire logic pullLow,
  // resolved wire level
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  // any party pulling wins, else the pull-up gives high
  assign pinLevel = (rstPinOe ? rstPinOut : 1'b1) & ~pullLow;
endmodule

// File: dv/reset_sequencer_tb_top.sv
/*
  self-checking bench for the reset sequencer: reset causes, sequence
  timing, register port and auxiliary detector. assumes the partner model.
*/
module reset_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, rstPinIn, rstPinOut, rstPinOe, lowSupplyCmp, watchdogUnderflow;
  logic auxCmpSupply, auxCmpPin, auxIrqAck, auxSourceSel, oscKeepRunning, pullLow;
  logic cpuReset, vectorFetch, cpuRun, auxIrq, rdPend;
  logic [1:0]  lvdThresholdSel, auxThresholdSel;
  logic [7:0]  regRdData;
  logic [15:0] vectorAddr;
  logic [31:0] lfsr;
  logic [7:0]  expQ[$];
  int          errCount, checksDone;
  reset_sequencer_pkg::reg_req_s regReq;
  reset_sequencer_pkg::options_s opts;

  reset_sequencer #(.SHORT_DELAY(16), .LONG_DELAY(64), .STRETCH_CYCLES(8)) dut (
    .clk, .rst, .regReq, .regRdData, .rstPinIn, .rstPinOut, .rstPinOe, .opts,
    .lowSupplyCmp, .watchdogUnderflow, .auxCmpSupply, .auxCmpPin, .auxIrqAck,
    .lvdThresholdSel, .auxThresholdSel, .auxSourceSel, .oscKeepRunning, .cpuReset,
    .vectorFetch, .vectorAddr, .cpuRun, .auxIrq);

  reset_pin_partner partner (.rstPinOe, .rstPinOut, .pullLow, .pinLevel(rstPinIn));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsrNext(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(logic [15:0] got, logic [15:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    regReq <= '0;
  endtask

  // read strobe, expected data noted for the monitor
  task automatic rd(logic [7:0] a, logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    regReq <= '0;
  endtask

  task automatic expIrq(logic e);
    step(3);
    check(auxIrq, e);
  endtask

  task automatic ackIrq();
    auxIrqAck <= 1'b1;
    step(1);
    auxIrqAck <= 1'b0;
    expIrq(1'b0);
  endtask

  // waits for the fetch, then checks both vector cycles and run entry
  task automatic waitRun();
    int n;
    n = 0;
    while (vectorFetch !== 1'b1 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    check(n < 600, 1'b1);
    check(rstPinOut, 1'b0);
    check(vectorAddr, reset_sequencer_pkg::VECTOR_LO_ADDR);
    @(posedge clk);
    check(vectorAddr, reset_sequencer_pkg::VECTOR_HI_ADDR);
    @(posedge clk);
    check({vectorFetch, cpuRun, cpuReset}, 3'b010);
  endtask

  // monitor: read data one cycle after the taken strobe
  always @(posedge clk)
  begin
    if (rdPend === 1'b1)
      check(regRdData, expQ.pop_front());
    rdPend <= regReq.rd;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    printVerdict();
  end

  initial
  begin
    {rst, pullLow} = 2'b11; // outside holds pin while memory blank
    regReq = '0;
    opts = '{1'b0, 1'b1, 2'b01, 1'b1};
    {lowSupplyCmp, watchdogUnderflow, auxCmpSupply, auxCmpPin, auxIrqAck, rdPend} = '0;
    {errCount, checksDone} = '0;
    lfsr = 32'hb746;
    step(20);
    rst <= 1'b0;
    step(30);
    pullLow <= 1'b0;
    waitRun();
    rd(8'h00, 8'h00);
    lfsr = lfsrNext(lfsr);
    wr(lfsr[7:0] | 8'h01, lfsr[15:8]);
    rd(lfsr[7:0] | 8'h01, 8'h00);
    $display("test reset and map done");
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hc0);
    check(auxSourceSel, 1'b1);
    auxCmpPin <= 1'b1;
    expIrq(1'b1);
    rd(8'h00, 8'he0);
    ackIrq();
    auxCmpPin <= 1'b0;
    expIrq(1'b1);
    ackIrq();
    wr(8'h00, 8'h00);
    auxCmpSupply <= 1'b1;
    expIrq(1'b0);
    wr(8'h00, 8'h40);
    expIrq(1'b1);
    ackIrq();
    auxCmpSupply <= 1'b0;
    expIrq(1'b1);
    ackIrq();
    $display("test aux detector done");
    watchdogUnderflow <= 1'b1;
    step(1);
    watchdogUnderflow <= 1'b0;
    waitRun();
    rd(8'h00, 8'h01);
    lowSupplyCmp <= 1'b1;
    step(30);
    check(cpuReset, 1'b1);
    lowSupplyCmp <= 1'b0;
    waitRun();
    rd(8'h00, 8'h10);
    watchdogUnderflow <= 1'b1;
    step(1);
    watchdogUnderflow <= 1'b0;
    waitRun();
    rd(8'h00, 8'h11);
    wr(8'h00, 8'h10);
    rd(8'h00, 8'h10);
    $display("test reset causes done");
    for (int i = 0; i < 2; i++)
    begin
      pullLow <= 1'b1;
      step(i == 0 ? 2 : 40);
      pullLow <= 1'b0;
      waitRun();
    end
    $display("test external pin done");
    lfsr = lfsrNext(lfsr);
    rst <= 1'b1;
    opts <= '{1'b1, 1'b0, lfsr[1:0], lfsr[2]};
    step(20);
    rst <= 1'b0;
    waitRun();
    lowSupplyCmp <= 1'b1;
    auxCmpSupply <= 1'b1;
    step(5);
    check(cpuRun, 1'b1);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h40);
    expIrq(1'b0);
    lowSupplyCmp <= 1'b0;
    auxCmpSupply <= 1'b0;
    step(3);
    $display("test detector disabled done");
    printVerdict();
  end
endmodule
